//--- design/bms_pkg.sv
// constants and types shared by the burst mode sequencer
package bms_pkg;
   // clock and settling time
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned SETTLE_NS = 50000;
   // least time, so round up to whole cycles
   localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 14;

   // bit positions inside the synchronised input vector
   localparam int unsigned SYNC_W = 6;
   localparam int unsigned IDX_BURST_HIGH = 0;
   localparam int unsigned IDX_PFC_AT_REG = 1;
   localparam int unsigned IDX_PFC_STOPPED = 2;
   localparam int unsigned IDX_LS_GATE = 3;
   localparam int unsigned IDX_STATE_HIGH = 4;
   localparam int unsigned IDX_PROT_RESTART = 5;

   // synchroniser reset value: comparator outputs read low
   localparam logic [SYNC_W-1:0] SYNC_RST = 6'h00;
   localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;

   // gray coded along run -> stopping -> stop -> settle -> run
   typedef enum logic [1:0] {
      BMS_RUN = 2'h0,
      BMS_STOPPING = 2'h1,
      BMS_STOP = 2'h3,
      BMS_SETTLE = 2'h2
   } bms_state_e;
endpackage

//--- design/bms_sync.sv
// two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module bms_sync #(
   parameter int unsigned WIDTH = 6
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // bits are unrelated levels, so per-bit crossing is safe
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;
endmodule

//--- design/bms_burst_sequencer.sv
// burst mode sequencer for the power factor stage and resonant half bridge
// Behaviour
// - A burst sense input below its reference suspends the half bridge and starts stopping.
// - Meanwhile the power factor stage keeps switching while boost output is below regulation.
// - Once the power factor stage reaches regulation during a stop request it soft-stops.
// - The half bridge ceases switching as soon as the low side gate becomes active.
// - The burst stop state is entered only once both stages have stopped, and consumption drops.
// - In the burst stop state the state output pin is pulled low.
// - The burst stop state is left when the burst sense input rises above the upper threshold.
// - After leaving the stop state a settling interval of about 50 us passes before a new burst.
// - Each new burst starts the power factor stage with a soft-start.
// - Each new burst resumes the half bridge directly at its working point without soft-start.
// - Burst mode stays off after power-up until the state output pin has once exceeded 2.5 V.
// - The 3 uA hysteresis sink is on while the burst sense input is low and off once it is high.
// - Both stages burst together, the power factor stage following the half bridge repetition.
// - A burst restart never applies the half bridge frequency reset of protection restarts.
`timescale 1ns/1ps
module bms_burst_sequencer #(
   parameter logic [bms_pkg::CNT_W-1:0] SETTLE_CYC_P = 14'(bms_pkg::SETTLE_CYC)
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // comparators, asynchronous to clk_i
   input wire logic burst_sense_high_i,
   input wire logic pfc_at_reg_i,
   input wire logic pfc_stopped_i,
   input wire logic low_side_gate_i,
   input wire logic state_output_pin_i,
   input wire logic prot_restart_i,
   // stage control
   output logic hbc_run_o,
   output logic pfc_run_o,
   output logic pfc_softstop_o,
   output logic pfc_softstart_o,
   output logic hbc_freq_reset_o,
   // supply and hysteresis
   output logic low_power_o,
   output logic hyst_sink_en_o,
   output logic burst_enabled_o,
   // state output pin, open drain pull-low
   output logic state_output_pin_o,
   output logic state_output_pin_oe_o
);
   logic [bms_pkg::SYNC_W-1:0] sync_s;
   logic burst_hi_s;
   logic pfc_reg_s;
   logic pfc_stopped_s;
   logic ls_s;
   logic state_hi_s;
   logic prot_s;

   bms_pkg::bms_state_e state_reg;
   bms_pkg::bms_state_e state_next;
   logic [bms_pkg::CNT_W-1:0] cnt_reg;
   logic [bms_pkg::CNT_W-1:0] cnt_next;
   logic en_reg;
   logic en_next;
   logic hbc_reg;
   logic hbc_next;
   logic pfc_reg;
   logic pfc_next;
   logic sstop_reg;
   logic sstop_next;
   logic sstart_reg;
   logic sstart_next;
   logic frst_reg;
   logic frst_next;
   logic lp_reg;
   logic lp_next;
   logic sink_reg;
   logic sink_next;
   logic pin_reg;

   // every comparator level crosses into clk_i here
   bms_sync #(
      .WIDTH(bms_pkg::SYNC_W)
   ) u_sync (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .async_i({prot_restart_i, state_output_pin_i, low_side_gate_i,
                pfc_stopped_i, pfc_at_reg_i, burst_sense_high_i}),
      .sync_o(sync_s)
   );

   assign burst_hi_s = sync_s[bms_pkg::IDX_BURST_HIGH];
   assign pfc_reg_s = sync_s[bms_pkg::IDX_PFC_AT_REG];
   assign pfc_stopped_s = sync_s[bms_pkg::IDX_PFC_STOPPED];
   assign ls_s = sync_s[bms_pkg::IDX_LS_GATE];
   assign state_hi_s = sync_s[bms_pkg::IDX_STATE_HIGH];
   assign prot_s = sync_s[bms_pkg::IDX_PROT_RESTART];

   // next state of the sequencer and all of its outputs except the state pin level, which pin_reg holds low
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      en_next = en_reg | state_hi_s;
      hbc_next = hbc_reg;
      pfc_next = pfc_reg;
      sstop_next = sstop_reg & ~pfc_stopped_s;
      sstart_next = 1'b0;
      frst_next = prot_s; // protection only
      lp_next = 1'b0;
      sink_next = ~burst_hi_s;
      case (state_reg)
         bms_pkg::BMS_RUN: begin
            // both stages switch together during burst-on
            hbc_next = 1'b1;
            pfc_next = 1'b1;
            if (en_reg && !burst_hi_s) begin
               state_next = bms_pkg::BMS_STOPPING;
            end
         end
         bms_pkg::BMS_STOPPING: begin
            if (burst_hi_s) begin
               // load came back before stop: resume at once, no reset
               state_next = bms_pkg::BMS_RUN;
               hbc_next = 1'b1;
               pfc_next = 1'b1;
               sstop_next = 1'b0;
               sstart_next = ~pfc_reg;
            end else begin
               if (hbc_reg && ls_s) begin
                  hbc_next = 1'b0;
               end
               // keep boosting until regulation, then soft-stop
               if (pfc_reg && pfc_reg_s) begin
                  pfc_next = 1'b0;
                  sstop_next = 1'b1;
               end
               if (!hbc_reg && !pfc_reg && !sstop_reg && pfc_stopped_s) begin
                  state_next = bms_pkg::BMS_STOP;
                  lp_next = 1'b1;
               end
            end
         end
         bms_pkg::BMS_STOP: begin
            lp_next = 1'b1;
            if (burst_hi_s) begin
               state_next = bms_pkg::BMS_SETTLE;
               cnt_next = bms_pkg::CNT_ZERO;
               lp_next = 1'b0;
            end
         end
         bms_pkg::BMS_SETTLE: begin
            cnt_next = cnt_reg + bms_pkg::CNT_ONE;
            if (cnt_reg == SETTLE_CYC_P - bms_pkg::CNT_ONE) begin
               state_next = bms_pkg::BMS_RUN;
               hbc_next = 1'b1; // working point kept
               pfc_next = 1'b1;
               sstart_next = 1'b1;
            end
         end
         default: begin
            state_next = bms_pkg::BMS_RUN;
            hbc_next = 1'b0;
            pfc_next = 1'b0;
         end
      endcase
   end

   // stages stay off until the first cycle out of reset
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= bms_pkg::BMS_RUN;
         cnt_reg <= bms_pkg::CNT_ZERO;
         en_reg <= 1'b0;
         hbc_reg <= 1'b0;
         pfc_reg <= 1'b0;
         sstop_reg <= 1'b0;
         sstart_reg <= 1'b0;
         frst_reg <= 1'b0;
         lp_reg <= 1'b0;
         sink_reg <= 1'b0;
         pin_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         en_reg <= en_next;
         hbc_reg <= hbc_next;
         pfc_reg <= pfc_next;
         sstop_reg <= sstop_next;
         sstart_reg <= sstart_next;
         frst_reg <= frst_next;
         lp_reg <= lp_next;
         sink_reg <= sink_next;
         pin_reg <= 1'b0;
      end
   end

   // outputs straight from flip-flops
   assign hbc_run_o = hbc_reg;
   assign pfc_run_o = pfc_reg;
   assign pfc_softstop_o = sstop_reg;
   assign pfc_softstart_o = sstart_reg;
   assign hbc_freq_reset_o = frst_reg;
   assign low_power_o = lp_reg;
   assign hyst_sink_en_o = sink_reg;
   assign burst_enabled_o = en_reg;
   assign state_output_pin_o = pin_reg;
   assign state_output_pin_oe_o = lp_reg; // pulled low in stop

   // settle counter watch for assertions
   localparam logic [bms_pkg::CNT_W-1:0] SETTLE_LAST = SETTLE_CYC_P - bms_pkg::CNT_ONE;

   sequence s_stop_req;
      state_reg == bms_pkg::BMS_RUN && en_reg && !burst_hi_s;
   endsequence

   sequence s_wake;
      state_reg == bms_pkg::BMS_STOP && burst_hi_s;
   endsequence

   // state has already left settle when the half bridge output rises
   sequence s_restart;
      $rose(hbc_run_o) && $past(state_reg) == bms_pkg::BMS_SETTLE;
   endsequence

   property p_stop_req;
      @(posedge clk_i) disable iff (!arst_n_i)
      s_stop_req |=> state_reg == bms_pkg::BMS_STOPPING;
   endproperty
   a_stop_req: assert property (p_stop_req) else $error("stop request not taken");

   property p_pfc_hold;
      @(posedge clk_i) disable iff (!arst_n_i)
      state_reg == bms_pkg::BMS_STOPPING && !burst_hi_s && pfc_reg && !pfc_reg_s
         |=> pfc_run_o;
   endproperty
   a_pfc_hold: assert property (p_pfc_hold) else $error("pfc stopped below regulation");

   property p_soft_stop;
      @(posedge clk_i) disable iff (!arst_n_i)
      state_reg == bms_pkg::BMS_STOPPING && !burst_hi_s && pfc_reg && pfc_reg_s
         |=> !pfc_run_o && pfc_softstop_o;
   endproperty
   a_soft_stop: assert property (p_soft_stop) else $error("pfc halted, no soft-stop");

   property p_hbc_stop;
      @(posedge clk_i) disable iff (!arst_n_i)
      state_reg == bms_pkg::BMS_STOPPING && !burst_hi_s && ls_s |=> !hbc_run_o;
   endproperty
   a_hbc_stop: assert property (p_hbc_stop) else $error("half bridge kept switching");

   property p_stop_entry;
      @(posedge clk_i) disable iff (!arst_n_i)
      $rose(low_power_o) |-> !hbc_run_o && !pfc_run_o && state_output_pin_oe_o;
   endproperty
   a_stop_entry: assert property (p_stop_entry) else $error("stop with a stage active");

   property p_wake_settle;
      @(posedge clk_i) disable iff (!arst_n_i)
      s_wake |=> (!low_power_o && !state_output_pin_oe_o && !hbc_run_o) [*8];
   endproperty
   a_wake_settle: assert property (p_wake_settle) else $error("wake or settling wrong");

   property p_settle_len;
      @(posedge clk_i) disable iff (!arst_n_i)
      s_restart |-> $past(cnt_reg) == SETTLE_LAST;
   endproperty
   a_settle_len: assert property (p_settle_len) else $error("burst restarted early");

   property p_restart;
      @(posedge clk_i) disable iff (!arst_n_i)
      s_restart |-> pfc_softstart_o && pfc_run_o;
   endproperty
   a_restart: assert property (p_restart) else $error("restart without soft-start");

   // no frequency reset unless protection asked for one
   property p_no_frst;
      @(posedge clk_i) disable iff (!arst_n_i)
      !$past(prot_s) |-> !hbc_freq_reset_o;
   endproperty
   a_no_frst: assert property (p_no_frst) else $error("unasked frequency reset");

   // in run both stages switch, the pfc follows the half bridge
   property p_together;
      @(posedge clk_i) disable iff (!arst_n_i)
      state_reg == bms_pkg::BMS_RUN |=> hbc_run_o && pfc_run_o;
   endproperty
   a_together: assert property (p_together) else $error("stages not bursting together");

   // soft-start is a single cycle strobe
   property p_sstart_pulse;
      @(posedge clk_i) disable iff (!arst_n_i)
      pfc_softstart_o |=> !pfc_softstart_o;
   endproperty
   a_sstart_pulse: assert property (p_sstart_pulse) else $error("soft-start too long");

   // stop state holds the state pin low
   property p_pin_low;
      @(posedge clk_i) disable iff (!arst_n_i)
      low_power_o |-> state_output_pin_oe_o && !state_output_pin_o;
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("state pin not pulled low");

   property p_enable;
      @(posedge clk_i) disable iff (!arst_n_i)
      !burst_enabled_o |-> state_reg == bms_pkg::BMS_RUN;
   endproperty
   a_enable: assert property (p_enable) else $error("burst active before enable");

   property p_sink;
      @(posedge clk_i) disable iff (!arst_n_i)
      !burst_hi_s [*2] |-> hyst_sink_en_o;
   endproperty
   a_sink: assert property (p_sink) else $error("hysteresis sink off while low");
endmodule

//--- dv/bms_far_model.sv
// far side model: comparators, low side gate driver and boost stage
`timescale 1ns/1ps
module bms_far_model #(
   parameter int RISE = 40
) (
   // clock, reset and bench controls
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic burst_hi_cmd_i,
   input wire logic at_reg_cmd_i,
   input wire logic gate_hold_i,
   // from the sequencer
   input wire logic hbc_run_i,
   input wire logic pfc_run_i,
   input wire logic softstop_i,
   input wire logic pin_oe_i,
   // comparators and gate feedback
   output logic burst_hi_o,
   output logic at_reg_o,
   output logic stopped_o,
   output logic ls_gate_o,
   output logic pin_hi_o
);
   int pin_cnt;
   int stop_cnt;
   logic [2:0] ph;
   // the pin charges through its pull-up unless pulled low, so it dips in stop
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_cnt <= 0;
         stop_cnt <= 0;
         ph <= 3'h0;
         burst_hi_o <= 1'b1;
         at_reg_o <= 1'b0;
         stopped_o <= 1'b0;
         ls_gate_o <= 1'b0;
         pin_hi_o <= 1'b0;
      end else begin
         burst_hi_o <= burst_hi_cmd_i;
         at_reg_o <= at_reg_cmd_i;
         ph <= ph + 3'h1;
         ls_gate_o <= hbc_run_i && !gate_hold_i && ph[2];
         stop_cnt <= softstop_i ? stop_cnt + 1 : 0;
         stopped_o <= pfc_run_i ? 1'b0 : (stopped_o || stop_cnt >= 6);
         pin_cnt <= pin_oe_i ? 0 : (pin_cnt < RISE ? pin_cnt + 1 : pin_cnt);
         pin_hi_o <= !pin_oe_i && pin_cnt >= RISE;
      end
   end
endmodule

//--- dv/bms_burst_sequencer_test.sv
// self-checking bench for the burst mode sequencer
`timescale 1ns/1ps
module bms_burst_sequencer_test;
   localparam logic [13:0] SETTLE = 14'h0010;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic burst_cmd = 1'b1;
   logic reg_cmd = 1'b0;
   logic hold = 1'b0;
   logic prot_restart_i = 1'b0;
   logic burst_sense_high_i, pfc_at_reg_i, pfc_stopped_i, low_side_gate_i, state_output_pin_i;
   logic hbc_run_o, pfc_run_o, pfc_softstop_o, pfc_softstart_o, hbc_freq_reset_o;
   logic low_power_o, hyst_sink_en_o, burst_enabled_o, state_output_pin_o, state_output_pin_oe_o;
   int errors = 0;
   int compares = 0;
   int n;
   // short settle so the run stays brief
   bms_burst_sequencer #(.SETTLE_CYC_P(SETTLE)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .burst_sense_high_i(burst_sense_high_i), .pfc_at_reg_i(pfc_at_reg_i),
      .pfc_stopped_i(pfc_stopped_i), .low_side_gate_i(low_side_gate_i),
      .state_output_pin_i(state_output_pin_i), .prot_restart_i(prot_restart_i),
      .hbc_run_o(hbc_run_o), .pfc_run_o(pfc_run_o), .pfc_softstop_o(pfc_softstop_o),
      .pfc_softstart_o(pfc_softstart_o), .hbc_freq_reset_o(hbc_freq_reset_o),
      .low_power_o(low_power_o), .hyst_sink_en_o(hyst_sink_en_o),
      .burst_enabled_o(burst_enabled_o), .state_output_pin_o(state_output_pin_o),
      .state_output_pin_oe_o(state_output_pin_oe_o));
   bms_far_model far (.clk_i(clk_i), .arst_n_i(arst_n_i), .burst_hi_cmd_i(burst_cmd),
      .at_reg_cmd_i(reg_cmd), .gate_hold_i(hold), .hbc_run_i(hbc_run_o), .pfc_run_i(pfc_run_o),
      .softstop_i(pfc_softstop_o), .pin_oe_i(state_output_pin_oe_o),
      .burst_hi_o(burst_sense_high_i), .at_reg_o(pfc_at_reg_i), .stopped_o(pfc_stopped_i),
      .ls_gate_o(low_side_gate_i), .pin_hi_o(state_output_pin_i));
   // 200 MHz clock
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic chk(input logic exp, input logic got, input string msg);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic chk_n(input int exp, input int got, input string msg);
      compares++;
      if (got != exp) begin
         errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   function automatic logic get(input int sel);
      case (sel)
         0: get = hbc_run_o;
         1: get = pfc_run_o;
         2: get = low_power_o;
         default: get = burst_enabled_o;
      endcase
   endfunction
   // bounded wait, sampling just after each edge
   task automatic wait_val(input int sel, input logic val, input int max, output int cnt);
      cnt = 0;
      while (get(sel) !== val && cnt < max) begin
         @(posedge clk_i);
         #1;
         cnt++;
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask
   // stop requests are ignored until the state pin has charged once
   task automatic t_startup;
      burst_cmd = 1'b0;
      cyc(6);
      chk(1'b1, hyst_sink_en_o, "sink off while low");
      chk(1'b0, burst_enabled_o, "enabled too early");
      chk(1'b1, hbc_run_o, "stopped while disabled");
      hold = 1'b1;
      wait_val(3, 1'b1, 100, n);
      chk(1'b1, burst_enabled_o, "never enabled");
      cyc(20);
      chk(1'b1, hbc_run_o, "hbc stopped before gate");
      hold = 1'b0;
      wait_val(0, 1'b0, 16, n);
      chk(1'b0, hbc_run_o, "hbc kept running");
   endtask
   // full stop and wake, timing the settle span
   task automatic t_burst;
      cyc(10);
      chk(1'b1, pfc_run_o, "pfc halted below regulation");
      chk(1'b0, low_power_o, "stop with pfc running");
      reg_cmd = 1'b1;
      wait_val(1, 1'b0, 10, n);
      chk(1'b1, pfc_softstop_o, "no soft-stop");
      wait_val(2, 1'b1, 40, n);
      chk(1'b1, low_power_o, "stop state not reached");
      chk(1'b0, pfc_softstop_o, "soft-stop held in stop");
      chk(1'b1, state_output_pin_oe_o, "pin not pulled");
      chk(1'b0, state_output_pin_o, "pin driven high");
      cyc(10);
      chk(1'b1, burst_enabled_o, "enable lost on pin dip");
      burst_cmd = 1'b1;
      wait_val(2, 1'b0, 10, n);
      chk(1'b0, low_power_o, "stop state kept");
      chk(1'b0, hyst_sink_en_o, "sink left on");
      wait_val(0, 1'b1, 100, n);
      chk_n(int'(SETTLE), n, "settle count");
      chk(1'b1, pfc_softstart_o, "no pfc soft-start");
      chk(1'b1, pfc_run_o, "pfc not with hbc");
      chk(1'b0, hbc_freq_reset_o, "hbc frequency reset");
      cyc(1);
      chk(1'b0, pfc_softstart_o, "soft-start pulse too long");
   endtask
   // a stop withdrawn midway resumes at once
   task automatic t_abort;
      reg_cmd = 1'b0;
      cyc(4);
      burst_cmd = 1'b0;
      wait_val(0, 1'b0, 20, n);
      chk(1'b1, pfc_run_o, "pfc halted below regulation");
      burst_cmd = 1'b1;
      wait_val(0, 1'b1, 8, n);
      chk(1'b1, hbc_run_o, "no direct resume");
      chk(1'b0, hbc_freq_reset_o, "frequency reset on resume");
      chk(1'b0, pfc_softstart_o, "soft-start on abort");
      chk(1'b0, low_power_o, "stop state on abort");
   endtask
   // protection restarts still reach the frequency reset
   task automatic t_prot;
      prot_restart_i = 1'b1;
      cyc(4);
      chk(1'b1, hbc_freq_reset_o, "no frequency reset");
      prot_restart_i = 1'b0;
      cyc(4);
      chk(1'b0, hbc_freq_reset_o, "frequency reset stuck");
   endtask
   task automatic test_done;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      cyc(16);
      arst_n_i = 1'b1;
      t_startup();
      t_burst();
      t_abort();
      t_prot();
      test_done();
   end
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #100000;
      errors++;
      test_done();
   end
endmodule
